// ### src/acr_pkg.sv
/*
 * Constants for the converter control and result block: register offsets,
 * field positions, mode and clock-source codes, bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with each register in one word.
 */
// Overview of operation
// - Busy flag sets when a conversion starts, clears on completion or abort.
// - With software trigger chosen, writing control one starts a conversion.
// - With hardware trigger chosen, the trigger input starts conversions, not writes.
// - Control two bit 5 turns the automatic compare on or off.
// - Bit 4 clear: true when result below value; set: at or above.
// - Result high holds upper bits per mode; unused upper bits read zero.
// - Results update at each completion unless compare enabled and unmet.
// - On a compare event the stored result is result minus compare value.
// - In 12/10-bit mode, high read blocks new results until low read.
// - In 8-bit mode no interlock between high and low result reads.
// - After a mode change results are invalid until a new conversion.
// - Compare high supplies upper compare bits per mode; unused in 8-bit.
// - Compare low always compares with the lower eight result bits.
// - Config bit 7 picks high speed when clear, low power when set.
// - Config bits 6:5 divide the selected clock by 1, 2, 4 or 8.
// - Config bit 4 picks short sample when clear, long when set.
// - Config bits 3:2 pick 8-, 12- or 10-bit mode; 11 reserved.
// - Config bits 1:0 pick bus, bus/2, alternate or asynchronous clock.
// - Done flag sets each completion, or only on true compare when enabled.
// - A control one write aborts; in software mode it restarts unless channel is all ones.
// - Raw result is rounded to 10 or 8 bits in those modes.
package acr_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_SC1 = 8'h00;
   localparam logic [7:0] OFF_SC2 = 8'h04;
   localparam logic [7:0] OFF_RH  = 8'h08;
   localparam logic [7:0] OFF_RL  = 8'h0C;
   localparam logic [7:0] OFF_CVH = 8'h10;
   localparam logic [7:0] OFF_CVL = 8'h14;
   localparam logic [7:0] OFF_CFG = 8'h18;
   // Field positions
   localparam int SC1_DONE  = 7;
   localparam int SC2_ACT   = 7;
   localparam int SC2_TRG   = 6;
   localparam int SC2_CMPEN = 5;
   localparam int SC2_GT    = 4;
   localparam int CFG_LP    = 7;
   localparam int CFG_LSMP  = 4;
   localparam logic [4:0] CH_OFF   = 5'h1F;
   localparam logic [7:0] REG_RST  = 8'h00;
   localparam logic [11:0] RES_RST = 12'h000;
   // Mode codes
   typedef enum logic [1:0] {
      MODE_8  = 2'b00,
      MODE_12 = 2'b01,
      MODE_10 = 2'b10,
      MODE_RSV = 2'b11
   } acr_mode_t;
   localparam logic [11:0] MASK_12 = 12'h0FFF;
   localparam logic [11:0] MASK_10 = 12'h03FF;
   localparam logic [11:0] MASK_8  = 12'h00FF;
   // Clock source codes
   typedef enum logic [1:0] {
      CK_BUS   = 2'b00,
      CK_BUS2  = 2'b01,
      CK_ALT   = 2'b10,
      CK_ASYNC = 2'b11
   } acr_clksel_t;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage : acr_pkg

// ### src/acr_top.sv
/*
 * Control, compare, result and configuration logic of the successive
 * approximation converter, with an AXI4-Lite register slave.
 * Assumes the analog core starts on conv_start_q, drops on conv_abort_q,
 * paces itself with conv_clk_tick_q and reports a raw 12-bit value with a
 * one-cycle core_done pulse. Hardware trigger and clock pins are sampled.
 */
module acr_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              hw_trigger_in,
   input  wire logic              alternate_clock,
   input  wire logic              async_converter_clock,
   input  wire logic              core_done,
   input  wire logic [11:0]       core_data,
   output logic                   conv_start_q,
   output logic                   conv_abort_q,
   output logic                   conv_in_progress_flag,
   output logic                   conv_clk_tick_q,
   output logic                   low_power_select,
   output logic                   long_sample_select,
   output logic [1:0]             conv_mode
);
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0]  wdata_q;
   logic        wstrb0_q;
   logic [4:0]  chan_q;
   logic        trg_q, cmpen_q, gt_q, done_q, act_q, lock_q;
   logic [7:0]  cvh_q, cvl_q, cfg_q;
   logic [11:0] res_q;
   logic        wr_fire, rd_fire, wr_sc1, rd_rh, rd_rl;
   logic [2:0]  hwt_q;
   logic        hw_edge, sw_start, start, abort;
   logic [1:0]  mode;
   logic [11:0] val, cv, mask, diff;
   logic [10:0] sum10;
   logic [8:0]  sum8;
   logic        cond, accept, upd;
   logic [2:0]  alt_q, asy_q;
   logic        half_q, src_tick;
   logic [2:0]  div_cnt_q, div_mask;
   logic [7:0]  rd_byte;
   logic        rd_hit;

   // Configuration fields drive the analog core directly
   assign mode      = cfg_q[3:2];
   assign conv_mode = cfg_q[3:2];
   assign low_power_select   = cfg_q[acr_pkg::CFG_LP];
   assign long_sample_select = cfg_q[acr_pkg::CFG_LSMP];
   assign conv_in_progress_flag = act_q;

   // Write completes once address and data are both held
   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign wr_sc1  = wr_fire && wstrb0_q && (8'(awaddr_q) == acr_pkg::OFF_SC1);
   assign rd_rh   = rd_fire && (8'(s_axi_araddr) == acr_pkg::OFF_RH);
   assign rd_rl   = rd_fire && (8'(s_axi_araddr) == acr_pkg::OFF_RL);

   // Write address channel
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_awready <= 1'b1;
         awaddr_q      <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         awaddr_q      <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   // Write data channel; only byte lane 0 carries register bits
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_wready <= 1'b1;
         wdata_q      <= acr_pkg::REG_RST;
         wstrb0_q     <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         wdata_q      <= s_axi_wdata[7:0];
         wstrb0_q     <= s_axi_wstrb[0];
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Write response; unmapped offsets answer with a decode error
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= acr_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         unique case (8'(awaddr_q))
            acr_pkg::OFF_SC1, acr_pkg::OFF_SC2, acr_pkg::OFF_RH, acr_pkg::OFF_RL,
            acr_pkg::OFF_CVH, acr_pkg::OFF_CVL, acr_pkg::OFF_CFG:
               s_axi_bresp <= acr_pkg::RESP_OKAY;
            default: s_axi_bresp <= acr_pkg::RESP_DECERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Writable registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         chan_q  <= acr_pkg::CH_OFF;
         trg_q   <= 1'b0;
         cmpen_q <= 1'b0;
         gt_q    <= 1'b0;
         cvh_q   <= acr_pkg::REG_RST;
         cvl_q   <= acr_pkg::REG_RST;
         cfg_q   <= acr_pkg::REG_RST;
      end else if (wr_fire && wstrb0_q) begin
         unique case (8'(awaddr_q))
            acr_pkg::OFF_SC1: chan_q <= wdata_q[4:0];
            acr_pkg::OFF_SC2: begin
               // Low four bits are not stored, so stray ones do no harm
               trg_q   <= wdata_q[acr_pkg::SC2_TRG];
               cmpen_q <= wdata_q[acr_pkg::SC2_CMPEN];
               gt_q    <= wdata_q[acr_pkg::SC2_GT];
            end
            acr_pkg::OFF_CVH: cvh_q <= wdata_q;
            acr_pkg::OFF_CVL: cvl_q <= wdata_q;
            acr_pkg::OFF_CFG: cfg_q <= wdata_q;          // results left stale
            default: ;
         endcase
      end
   end

   // Read channel with data captured at the address handshake
   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = acr_pkg::REG_RST;
      unique case (8'(s_axi_araddr))
         acr_pkg::OFF_SC1: rd_byte = {done_q, 2'b00, chan_q};
         acr_pkg::OFF_SC2: rd_byte = {act_q, trg_q, cmpen_q, gt_q, 4'h0};
         acr_pkg::OFF_RH:  rd_byte = {4'h0, res_q[11:8]};
         acr_pkg::OFF_RL:  rd_byte = res_q[7:0];
         acr_pkg::OFF_CVH: rd_byte = cvh_q;
         acr_pkg::OFF_CVL: rd_byte = cvl_q;
         acr_pkg::OFF_CFG: rd_byte = cfg_q;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= acr_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h00_0000, rd_byte};
         s_axi_rresp   <= rd_hit ? acr_pkg::RESP_OKAY : acr_pkg::RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   // Hardware trigger: two-stage synchroniser, third stage for the edge
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) hwt_q <= 3'b000;
      else       hwt_q <= {hwt_q[1:0], hw_trigger_in};
   end
   // A held trigger yields one start; writes start nothing in hardware mode
   assign hw_edge  = hwt_q[1] && !hwt_q[2];
   assign sw_start = wr_sc1 && !trg_q && (wdata_q[4:0] != acr_pkg::CH_OFF);
   assign start    = sw_start || (hw_edge && trg_q && chan_q != acr_pkg::CH_OFF);
   assign abort    = wr_sc1;

   // Start and abort strobes to the analog core
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         conv_start_q <= 1'b0;
         conv_abort_q <= 1'b0;
      end else begin
         conv_start_q <= start;
         conv_abort_q <= abort;
      end
   end

   // Busy flag; a restarting write leaves it set
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)                 act_q <= 1'b0;
      else if (start)            act_q <= 1'b1;
      else if (abort || core_done) act_q <= 1'b0;
   end

   // Rounding of the raw value to the selected width
   assign sum10 = {1'b0, core_data[11:2]} + 11'(core_data[1]);
   assign sum8  = {1'b0, core_data[11:4]} + 9'(core_data[3]);
   always_comb begin
      unique case (mode)
         acr_pkg::MODE_12: begin
            val  = core_data;
            cv   = {cvh_q[3:0], cvl_q};
            mask = acr_pkg::MASK_12;
         end
         acr_pkg::MODE_10: begin
            val  = sum10[10] ? acr_pkg::MASK_10 : {2'b00, sum10[9:0]};
            cv   = {2'b00, cvh_q[1:0], cvl_q};
            mask = acr_pkg::MASK_10;
         end
         default: begin
            // Reserved mode rounds and compares as 8-bit but keeps the read interlock
            val  = sum8[8] ? acr_pkg::MASK_8 : {4'h0, sum8[7:0]};
            cv   = {4'h0, cvl_q};
            mask = acr_pkg::MASK_8;
         end
      endcase
   end

   // Compare and the value stored on a compare event
   assign cond   = gt_q ? (val >= cv) : (val < cv);
   assign diff   = (val + ~cv + 12'h001) & mask;
   assign accept = core_done && act_q && (!cmpen_q || cond);
   assign upd    = accept && !lock_q;

   // Result registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)    res_q <= acr_pkg::RES_RST;
      else if (upd) res_q <= cmpen_q ? diff : val;
   end

   // High-then-low read interlock, absent in 8-bit mode
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)                                   lock_q <= 1'b0;
      else if (rd_rl || mode == acr_pkg::MODE_8)   lock_q <= 1'b0;
      else if (rd_rh)                              lock_q <= 1'b1;
   end

   // Done flag: a completion in the clearing cycle wins
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)               done_q <= 1'b0;
      else if (accept)         done_q <= 1'b1;
      else if (wr_sc1 || rd_rl) done_q <= 1'b0;
   end

   // Clock-source pins: synchronised, rising edges become ticks
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         alt_q  <= 3'b000;
         asy_q  <= 3'b000;
         half_q <= 1'b0;
      end else begin
         alt_q  <= {alt_q[1:0], alternate_clock};
         asy_q  <= {asy_q[1:0], async_converter_clock};
         half_q <= !half_q;
      end
   end

   // Source pick; pin clocks are limited to under a quarter of ref_clk
   always_comb begin
      unique case (cfg_q[1:0])
         acr_pkg::CK_BUS:   src_tick = 1'b1;
         acr_pkg::CK_BUS2:  src_tick = half_q;
         acr_pkg::CK_ALT:   src_tick = alt_q[1] && !alt_q[2];
         acr_pkg::CK_ASYNC: src_tick = asy_q[1] && !asy_q[2];
      endcase
   end
   assign div_mask = 3'((4'h1 << cfg_q[6:5]) - 4'h1);

   // Divider producing the converter clock tick
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         div_cnt_q       <= 3'b000;
         conv_clk_tick_q <= 1'b0;
      end else begin
         conv_clk_tick_q <= src_tick && ((div_cnt_q & div_mask) == div_mask);
         if (src_tick) div_cnt_q <= div_cnt_q + 3'b001;
      end
   end

   // Checks stay quiet while reset is held
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence hw_rise_s;
      !hwt_q[1] ##1 hwt_q[1] && trg_q && chan_q != acr_pkg::CH_OFF && !wr_sc1;
   endsequence

   sequence off_write_s;
      wr_sc1 && wdata_q[4:0] == acr_pkg::CH_OFF;
   endsequence

   act_set_a: assert property (start |=> act_q)
      else $error("busy flag not set after start");
   act_clr_a: assert property (core_done && !start |=> !act_q)
      else $error("busy flag not cleared at completion");
   sw_start_a: assert property (sw_start |=> conv_start_q && conv_abort_q)
      else $error("software start not issued");
   hw_start_a: assert property (hw_rise_s |-> ##[1:2] conv_start_q)
      else $error("hardware trigger did not start");
   hw_only_a: assert property (trg_q && $rose(conv_start_q) |-> $past(hw_edge))
      else $error("start without trigger edge");
   cmp_miss_a: assert property (core_done && cmpen_q && !cond
      |=> $stable(res_q) && !$rose(done_q))
      else $error("result changed on unmet compare");
   lock_hold_a: assert property (lock_q && !rd_rl |=> $stable(res_q))
      else $error("result changed while locked");
   mode8_lock_a: assert property (mode == acr_pkg::MODE_8 |=> !lock_q)
      else $error("interlock active in 8-bit mode");
   done_set_a: assert property (accept |=> done_q ##1 (done_q || $past(wr_sc1 || rd_rl)))
      else $error("done flag not set");
   width_clr_a: assert property (upd && mode != acr_pkg::MODE_12
      |=> res_q[11:10] == 2'b00)
      else $error("unused result bits not clear");
   abort_clr_a: assert property (abort && !start |=> !act_q)
      else $error("busy flag not cleared by abort");
   off_chan_a: assert property (off_write_s |=> conv_abort_q && !conv_start_q)
      else $error("start issued for off channel");
   hw_no_sw_a: assert property (wr_sc1 && trg_q && !hw_edge |=> !conv_start_q)
      else $error("write started in hardware mode");
   res8_clr_a: assert property (upd && mode == acr_pkg::MODE_8 |=> res_q[11:8] == 4'h0)
      else $error("upper result bits set in 8-bit mode");
   lock_set_a: assert property (rd_rh && mode != acr_pkg::MODE_8 |=> lock_q)
      else $error("high read did not lock results");
endmodule : acr_top

// ### verif/acr_core_model.sv
/*
 * Behavioural analog core: starts on a start pulse, answers lat + 2 cycles
 * after it with a one-cycle done pulse carrying raw_val.
 * Assumes start and abort arrive as one-cycle pulses from the control block.
 */
module acr_core_model (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        conv_start_q,
   input  wire logic        conv_abort_q,
   input  wire logic [11:0] raw_val,
   input  wire logic [7:0]  lat,
   output logic             core_done,
   output logic [11:0]      core_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       run_q;
   logic [7:0] cnt_q;
   logic       fin;
   // Finish only when no start or abort lands in the same cycle
   assign fin = run_q && cnt_q == 8'h00 && !conv_start_q && !conv_abort_q;
   // Conversion timer; a new start restarts it, an abort kills it
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         run_q <= 1'b0;
         cnt_q <= 8'h00;
      end else if (conv_start_q) begin
         run_q <= 1'b1;
         cnt_q <= lat;
      end else if (conv_abort_q || fin) begin
         run_q <= 1'b0;
      end else if (run_q) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
   // Data churns outside the pulse so a value sampled one cycle late never passes for the result
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         core_done <= 1'b0;
         core_data <= 12'h000;
      end else begin
         core_done <= fin;
         core_data <= fin ? raw_val : ~core_data;
      end
   end
endmodule : acr_core_model

// ### verif/tb.sv
/*
 * Self-checking bench: AXI4-Lite master tasks, integer model of results,
 * compare and flags, pulse counters on the core strobes and clock ticks.
 * Assumes acr_top and acr_core_model; bready and rready are held high.
 */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b1;
   logic        s_axi_rready = 1'b1;
   logic [1:0]  s_axi_bresp, s_axi_rresp, conv_mode, rsp;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic [31:0] s_axi_rdata, v;
   logic        hw_trigger_in = 1'b0;
   logic        alternate_clock = 1'b0;
   logic        async_converter_clock = 1'b0;
   logic        core_done, conv_start_q, conv_abort_q, conv_in_progress_flag;
   logic        conv_clk_tick_q, low_power_select, long_sample_select;
   logic [11:0] core_data;
   logic [11:0] raw_val = 12'h000;
   logic [7:0]  lat = 8'h03;
   logic [3:0]  ck_cnt = 4'h0;
   int n_fail = 0, total_checks = 0, seed = 35, n_start = 0, n_abort = 0, n_tick = 0, t0;
   int res_m = 0, done_m = 0, lock_m = 0, mode_m = 0, en_m = 0, gt_m = 0, cvh_m, cvl_m;
   int chan_m = 31;
   int per[4] = '{1, 2, 8, 16};
   logic [7:0]  offs[6] = '{acr_pkg::OFF_SC2, acr_pkg::OFF_RH, acr_pkg::OFF_RL,
                            acr_pkg::OFF_CVH, acr_pkg::OFF_CVL, acr_pkg::OFF_CFG};

   acr_top #(.ADDR_W(8)) dut_u (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .hw_trigger_in, .alternate_clock, .async_converter_clock,
      .core_done, .core_data, .conv_start_q, .conv_abort_q, .conv_in_progress_flag,
      .conv_clk_tick_q, .low_power_select, .long_sample_select, .conv_mode);
   acr_core_model core_u (.ref_clk, .nrst, .conv_start_q, .conv_abort_q, .raw_val, .lat,
      .core_done, .core_data);

   always #10 ref_clk = ~ref_clk;
   // Side clocks well below a quarter of ref_clk: periods of 8 and 16 cycles
   always @(posedge ref_clk) begin
      ck_cnt <= ck_cnt + 4'h1;
      alternate_clock <= ck_cnt[2];
      async_converter_clock <= ck_cnt[3];
   end
   // Pulse counters for starts, aborts and converter clock ticks
   always @(posedge ref_clk) begin
      n_start <= n_start + (conv_start_q === 1'b1);
      n_abort <= n_abort + (conv_abort_q === 1'b1);
      n_tick <= n_tick + (conv_clk_tick_q === 1'b1);
   end

   task automatic report_and_stop();
      if (n_fail == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string w);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, w);
      end
   endtask : chk

   // Address and data offered together, each dropped at its own handshake
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      bit aw_ok = 0;
      bit w_ok = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge ref_clk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : bus_rd

   task automatic rd_chk(input logic [7:0] a, input int e, input string w);
      logic [31:0] d;
      logic [1:0]  r;
      bus_rd(a, d, r);
      chk(32'(r), 32'(acr_pkg::RESP_OKAY), w);
      chk(d, 32'(e), w);
   endtask : rd_chk

   // Integer model of one completion: rounding, compare, result and done
   task automatic conv_model(input int raw);
      int r, cv, mask;
      bit hit;
      if (mode_m == 1) begin
         r = raw;
         cv = (cvh_m % 16) * 256 + cvl_m;
         mask = 4095;
      end else if (mode_m == 2) begin
         r = (raw + 2) / 4 > 1023 ? 1023 : (raw + 2) / 4;
         cv = (cvh_m % 4) * 256 + cvl_m;
         mask = 1023;
      end else begin
         r = (raw + 8) / 16 > 255 ? 255 : (raw + 8) / 16;
         cv = cvl_m;
         mask = 255;
      end
      hit = !en_m || (gt_m ? r >= cv : r < cv);
      if (hit) done_m = 1;
      if (hit && !lock_m) res_m = en_m ? (r - cv) & mask : r;
   endtask : conv_model

   task automatic do_conv(input int raw, input int l);
      raw_val <= 12'(raw);
      lat <= 8'(l);
      bus_wr(acr_pkg::OFF_SC1, 8'(chan_m), rsp);
      done_m = 0;
      chk(32'(conv_in_progress_flag), 32'h0000_0001, "busy");
      while (conv_in_progress_flag !== 1'b0) @(posedge ref_clk);
      @(posedge ref_clk);
      conv_model(raw);
   endtask : do_conv

   task automatic rd_res();
      rd_chk(acr_pkg::OFF_SC1, done_m * 128 + chan_m, "done");
      rd_chk(acr_pkg::OFF_RH, (res_m / 256) % 16, "res hi");
      rd_chk(acr_pkg::OFF_RL, res_m % 256, "res lo");
      done_m = 0;
   endtask : rd_res

   initial begin
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      // Reset values, an unmapped offset, a read-only write and a dropped strobe
      rd_chk(acr_pkg::OFF_SC1, 31, "sc1 rst");
      foreach (offs[i]) rd_chk(offs[i], 0, "rst");
      bus_rd(8'h1C, v, rsp);
      chk(32'(rsp), 32'(acr_pkg::RESP_DECERR), "rd decerr");
      bus_wr(8'h1C, 8'h5A, rsp);
      chk(32'(rsp), 32'(acr_pkg::RESP_DECERR), "wr decerr");
      bus_wr(acr_pkg::OFF_RL, 8'hFF, rsp);
      chk(32'(rsp), 32'(acr_pkg::RESP_OKAY), "ro okay");
      rd_chk(acr_pkg::OFF_RL, 0, "ro");
      s_axi_wstrb <= 4'h0;
      bus_wr(acr_pkg::OFF_CVL, 8'hA5, rsp);
      s_axi_wstrb <= 4'h1;
      rd_chk(acr_pkg::OFF_CVL, 0, "strobe");
      // Random configurations read back and reach the control outputs
      repeat (4) begin
         v = $random(seed);
         bus_wr(acr_pkg::OFF_CFG, v[7:0], rsp);
         rd_chk(acr_pkg::OFF_CFG, v[7:0], "cfg");
         chk(32'(low_power_select), 32'(v[7]), "lp");
         chk(32'(long_sample_select), 32'(v[4]), "ls");
         chk(32'(conv_mode), 32'(v[3:2]), "mode");
      end
      // Every source with every ratio; 128 cycles hold a whole number of tick periods
      for (int s = 0; s < 4; s++) begin
         for (int d = 0; d < 4; d++) begin
            bus_wr(acr_pkg::OFF_CFG, 8'(d * 32 + s), rsp);
            repeat (16) @(posedge ref_clk);
            t0 = n_tick;
            repeat (128) @(posedge ref_clk);
            chk(32'(n_tick - t0), 32'(128 / (per[s] << d)), "ticks");
         end
      end
      // All modes with compare off, below and at-or-above, two conversions each
      chan_m = 0;
      for (int m = 0; m < 4; m++) begin
         for (int c = 0; c < 3; c++) begin
            v = $random(seed);
            mode_m = m;
            en_m = c > 0;
            gt_m = c == 2;
            cvh_m = v[7:0];
            cvl_m = v[15:8];
            bus_wr(acr_pkg::OFF_CVH, v[7:0], rsp);
            bus_wr(acr_pkg::OFF_CVL, v[15:8], rsp);
            rd_chk(acr_pkg::OFF_CVH, cvh_m, "cvh");
            bus_wr(acr_pkg::OFF_SC2, 8'(en_m * 32 + gt_m * 16), rsp);
            rd_chk(acr_pkg::OFF_SC2, en_m * 32 + gt_m * 16, "sc2");
            bus_wr(acr_pkg::OFF_CFG, 8'(m * 4), rsp);
            repeat (2) begin
               v = $random(seed);
               do_conv(v[11:0], 3 + v[19:16]);
               rd_res();
            end
         end
      end
      // A high read holds off the next result in 12-bit mode but not in 8-bit
      en_m = 0;
      bus_wr(acr_pkg::OFF_SC2, 8'h00, rsp);
      for (int m = 1; m >= 0; m--) begin
         mode_m = m;
         bus_wr(acr_pkg::OFF_CFG, 8'(m * 4), rsp);
         v = $random(seed);
         do_conv(v[11:0], 4);
         rd_chk(acr_pkg::OFF_RH, (res_m / 256) % 16, "hi");
         lock_m = m;
         do_conv(v[23:12], 4);
         rd_chk(acr_pkg::OFF_RL, res_m % 256, "lock");
         lock_m = 0;
         done_m = 0;
         rd_res();
      end
      // A second control write mid-conversion aborts and restarts
      t0 = n_abort;
      lat <= 8'h28;
      bus_wr(acr_pkg::OFF_SC1, 8'h00, rsp);
      repeat (5) @(posedge ref_clk);
      v = $random(seed);
      do_conv(v[11:0], 3);
      chk(32'(n_abort - t0), 32'h0000_0002, "aborts");
      rd_res();
      // Channel all ones aborts without starting again
      t0 = n_start;
      lat <= 8'h28;
      bus_wr(acr_pkg::OFF_SC1, 8'h00, rsp);
      bus_wr(acr_pkg::OFF_SC1, 8'h1F, rsp);
      repeat (2) @(posedge ref_clk);
      chk(32'(conv_in_progress_flag), 32'h0000_0000, "off");
      chk(32'(n_start - t0), 32'h0000_0001, "starts");
      // Hardware trigger: writes start nothing, one held assertion gives one start
      bus_wr(acr_pkg::OFF_SC2, 8'h40, rsp);
      bus_wr(acr_pkg::OFF_SC1, 8'h00, rsp);
      chan_m = 0;
      done_m = 0;
      t0 = n_start;
      repeat (8) @(posedge ref_clk);
      chk(32'(n_start - t0), 32'h0000_0000, "no sw start");
      v = $random(seed);
      raw_val <= v[11:0];
      lat <= 8'h03;
      hw_trigger_in <= 1'b1;
      repeat (20) @(posedge ref_clk);
      hw_trigger_in <= 1'b0;
      chk(32'(n_start - t0), 32'h0000_0001, "hw start");
      conv_model(v[11:0]);
      rd_res();
      report_and_stop();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #1_000_000;
      n_fail++;
      report_and_stop();
   end
endmodule : tb
